/* File: include/egs_pkg.sv */
// Types shared by the gear slave control and its speed ramp
package egs_pkg;

  typedef logic signed [15:0] egs_speed_t;
  typedef logic [15:0]        egs_word_t;

  // Gear sequencer states
  typedef enum logic [2:0] {
    EGS_IDLE,
    EGS_RAMP_UP,
    EGS_IN_GEAR,
    EGS_HALTING,
    EGS_STOPPING
  } egs_gear_e;

endpackage : egs_pkg

/* File: include/egs_ramp_if.sv */
// Link between the gear sequencer and the speed ramp generator
`timescale 1ns/1ps
interface egs_ramp_if;
  import egs_pkg::*;

  egs_speed_t target;
  egs_word_t  step;
  egs_speed_t current;
  logic       at_target;

  modport ctrl (output target, output step, input current, input at_target);
  modport ramp (input target, input step, output current, output at_target);
endinterface : egs_ramp_if

/* File: include/egs_regs.svh */
// Register offsets, field positions, reset values and codes of the gear slave block
`ifndef EGS_REGS_SVH
`define EGS_REGS_SVH

// Register byte offsets on the APB
`define EGS_OFF_CMD      12'h000
`define EGS_OFF_COND     12'h004
`define EGS_OFF_MODE     12'h008
`define EGS_OFF_ACCEL    12'h00c
`define EGS_OFF_DECEL    12'h010
`define EGS_OFF_IRQ_STS  12'h014
`define EGS_OFF_IRQ_MASK 12'h018

// Command word bit positions
`define EGS_CMD_GEAR     4
`define EGS_CMD_CORR     5
`define EGS_CMD_SYNC     6
`define EGS_CMD_HALT     8
`define EGS_CMD_PHASE    9
`define EGS_CMD_PSEL_LO  12
`define EGS_CMD_PSEL_HI  13

// Condition word bit positions
`define EGS_STS_DONE     8
`define EGS_STS_IN_GEAR  10
`define EGS_STS_CORR_OK  12
`define EGS_STS_FOL_ERR  13

// Interrupt status and mask bit positions
`define EGS_IRQ_IN_GEAR  0
`define EGS_IRQ_PH_DONE  1
`define EGS_IRQ_CR_DONE  2
`define EGS_IRQ_FOL_ERR  3
`define EGS_IRQ_W        4

// Operating mode code for electronic gear slave (-3)
`define EGS_MODE_SLAVE   8'hfd

// Reset values
`define EGS_RST_CMD      16'h0000
`define EGS_RST_MODE     8'h00
`define EGS_RST_ACCEL    16'h0010
`define EGS_RST_DECEL    16'h0010
`define EGS_RST_IRQ      4'h0

// Step used when direct synchronisation skips the ramp
`define EGS_STEP_DIRECT  16'hffff

`endif

/* File: sim/egs_drive_model.sv */
// Drive plant model: reports phasing and correction completion after a run time
`timescale 1ns/1ps
module egs_drive_model #(
  parameter int DLY = 8
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ph_run,
  input  wire logic i_cr_run,
  output logic      o_ph_done,
  output logic      o_cr_done
);
  int ph_cnt;
  int cr_cnt;
  // Run time counters restart whenever an operation stops or is aborted
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_cnt <= 0;
      cr_cnt <= 0;
    end else begin
      ph_cnt <= i_ph_run ? ph_cnt + 1 : 0;
      cr_cnt <= i_cr_run ? cr_cnt + 1 : 0;
    end
  end
  // Completion is a single-cycle pulse, low while idle
  assign o_ph_done = i_ph_run && ph_cnt == DLY;
  assign o_cr_done = i_cr_run && cr_cnt == DLY;
endmodule : egs_drive_model

/* File: sim/egs_gear_slave_props.sv */
// Port checker of the gear slave control, bound to its top module
`timescale 1ns/1ps
module egs_gear_slave_props
  import egs_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_op_enabled,
  input wire logic        i_phasing_complete,
  input wire logic        i_correction_complete,
  input wire egs_speed_t  o_speed_ref,
  input wire logic        o_phasing_run,
  input wire logic [2:0]  o_phasing_profile,
  input wire logic        o_correction_run,
  input wire logic        o_halt_hold,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Bus answer only inside an enabled access phase
  ready_in_access_a: assert property (o_pready |-> i_psel && i_penable && i_ce)
    else $error("pready outside access phase");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  ready_no_wait_a: assert property (i_psel && !i_penable && i_ce ##1 i_psel && i_penable && i_ce |-> o_pready)
    else $error("access phase not answered");
  ro_write_err_a: assert property (i_psel && i_penable && i_pwrite && i_paddr == 12'h004 && o_pready |-> o_pslverr)
    else $error("write to condition word not refused");
  profile_range_a: assert property (o_phasing_profile inside {[3'h1:3'h4]})
    else $error("phasing profile out of range");
  phase_end_a: assert property (i_ce && o_phasing_run && i_phasing_complete |=> !o_phasing_run)
    else $error("phasing still runs after completion");
  corr_end_a: assert property (i_ce && o_correction_run && i_correction_complete |=> !o_correction_run)
    else $error("correction still runs after completion");
  halt_zero_a: assert property (i_ce && o_halt_hold && o_speed_ref == 16'sd0 |=> o_speed_ref == 16'sd0 || !o_halt_hold)
    else $error("speed left zero under halt");
  corr_abort_a: assert property (i_ce && !i_op_enabled |=> !o_correction_run)
    else $error("correction runs with drive disabled");
  ce_freeze_a: assert property (!i_ce |=> $stable(o_speed_ref) && $stable(o_irq))
    else $error("outputs moved with clock enable low");

  // Main scenarios reached
  phase_cov: cover property ($rose(o_phasing_run));
  corr_cov: cover property ($fell(o_correction_run));
  err_cov: cover property (o_pslverr);
  irq_cov: cover property ($rose(o_irq));
endmodule : egs_gear_slave_props

bind egs_gear_slave egs_gear_slave_props chk_u (.i_clk, .i_rst_n, .i_ce, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .o_pready, .o_pslverr, .i_op_enabled, .i_phasing_complete, .i_correction_complete,
  .o_speed_ref, .o_phasing_run, .o_phasing_profile, .o_correction_run, .o_halt_hold, .o_irq);

/* File: sim/egs_gear_slave_tb.sv */
// Testbench of the gear slave control: APB sequences with expected values
`timescale 1ns/1ps
`include "egs_regs.svh"
module egs_gear_slave_tb;
  import egs_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic        o_pready, o_pslverr, o_phasing_run, o_correction_run, o_halt_hold, o_irq, err;
  logic [2:0]  o_phasing_profile;
  logic        i_op_enabled = 1'b0, i_following_error = 1'b0, i_phasing_complete, i_correction_complete;
  egs_speed_t  i_master_speed = 16'sd0, o_speed_ref;
  int          mismatches = 0, n_compared = 0, cyc = 0;

  always #4 i_clk = ~i_clk;

  egs_gear_slave dut_u (.i_clk, .i_rst_n, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_op_enabled, .i_master_speed, .i_phasing_complete,
    .i_correction_complete, .i_following_error, .o_speed_ref, .o_phasing_run, .o_phasing_profile,
    .o_correction_run, .o_halt_hold, .o_irq);

  egs_drive_model #(.DLY(8)) drv_u (.i_clk, .i_rst_n, .i_ph_run(o_phasing_run), .i_cr_run(o_correction_run),
    .o_ph_done(i_phasing_complete), .o_cr_done(i_correction_complete));

  task close_out;
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task rc(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rc

  task cb(input int b, input logic v, input string m);
    chk(32'(rd[b]), 32'(v), m);
  endtask : cb

  // Poll the condition word until a bit takes a value, bounded
  task wb(input int b, input logic v, input string m);
    apb(1'b0, `EGS_OFF_COND, 32'h0);
    for (int k = 0; k < 60 && rd[b] !== v; k++) apb(1'b0, `EGS_OFF_COND, 32'h0);
    cb(b, v, m);
  endtask : wb

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Reset values and refused accesses
    rc(`EGS_OFF_CMD, 32'h0, "cmd reset");
    rc(`EGS_OFF_MODE, 32'h0, "mode reset");
    rc(`EGS_OFF_ACCEL, 32'h10, "accel reset");
    rc(`EGS_OFF_DECEL, 32'h10, "decel reset");
    rc(`EGS_OFF_IRQ_STS, 32'h0, "irq status reset");
    rc(`EGS_OFF_IRQ_MASK, 32'h0, "irq mask reset");
    apb(1'b1, `EGS_OFF_COND, 32'hffff);
    chk(32'(err), 32'h1, "cond write refused");
    rc(`EGS_OFF_COND, 32'h0, "cond unchanged");
    apb(1'b0, 12'h01c, 32'h0);
    chk(32'(err), 32'h1, "unmapped refused");
    // Gear in with direct sync, then interrupt mask and clear
    i_op_enabled <= 1'b1;
    i_master_speed <= 16'sd100;
    apb(1'b1, `EGS_OFF_CMD, 32'h0010);
    repeat (4) @(posedge i_clk);
    chk(32'(o_speed_ref), 32'h0, "no gear outside slave mode");
    apb(1'b1, `EGS_OFF_MODE, 32'hfd);
    wb(10, 1'b1, "in gear");
    chk(32'(o_speed_ref), 32'(16'sd100), "gear speed");
    rc(`EGS_OFF_IRQ_STS, 32'h1, "in gear event");
    chk(32'(o_irq), 32'h0, "irq masked");
    apb(1'b1, `EGS_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h1, "irq raised");
    apb(1'b1, `EGS_OFF_IRQ_STS, 32'h1);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h0, "irq cleared");
    i_ce <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_ce <= 1'b1;
    // Halt decelerates to zero and keeps the drive enabled
    apb(1'b1, `EGS_OFF_CMD, 32'h0110);
    apb(1'b0, `EGS_OFF_COND, 32'h0);
    cb(10, 1'b0, "decelerating");
    wb(10, 1'b1, "speed zero");
    chk(32'(o_speed_ref), 32'h0, "halted speed");
    chk(32'(o_halt_hold), 32'h1, "halt hold");
    // Halt released resumes the gear command
    apb(1'b1, `EGS_OFF_CMD, 32'h0010);
    wb(10, 1'b1, "regear");
    chk(32'(o_speed_ref), 32'(16'sd100), "regear speed");
    chk(32'(o_halt_hold), 32'h0, "halt released");
    // Gear bit cleared stops the drive
    apb(1'b1, `EGS_OFF_CMD, 32'h0000);
    for (int k = 0; k < 60 && o_speed_ref !== 16'sd0; k++) @(posedge i_clk);
    chk(32'(o_speed_ref), 32'h0, "stopped");
    // Position correction
    apb(1'b0, `EGS_OFF_COND, 32'h0);
    cb(12, 1'b0, "corr not started");
    apb(1'b1, `EGS_OFF_CMD, 32'h0020);
    wb(12, 1'b1, "corr done");
    cb(8, 1'b1, "done after corr");
    apb(1'b1, `EGS_OFF_CMD, 32'h0000);
    // Correction aborted by the drive leaving operation enabled
    apb(1'b1, `EGS_OFF_CMD, 32'h0020);
    repeat (2) @(posedge i_clk);
    chk(32'(o_correction_run), 32'h1, "corr running");
    i_op_enabled <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(32'(o_correction_run), 32'h0, "corr aborted");
    apb(1'b1, `EGS_OFF_CMD, 32'h0000);
    i_op_enabled <= 1'b1;
    apb(1'b0, `EGS_OFF_COND, 32'h0);
    cb(12, 1'b0, "no corr ok on abort");
    // Every phasing profile code
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, `EGS_OFF_CMD, 32'h0200 | (32'(n) << 12));
      repeat (2) @(posedge i_clk);
      chk(32'(o_phasing_profile), 32'(n + 1), "profile");
      chk(32'(o_phasing_run), 32'h1, "phasing run");
      apb(1'b0, `EGS_OFF_COND, 32'h0);
      cb(8, 1'b0, "no done while phasing");
      wb(8, 1'b1, "phasing done");
      apb(1'b1, `EGS_OFF_CMD, 32'h0000);
    end
    // Phasing aborted before completion
    apb(1'b1, `EGS_OFF_CMD, 32'h0200);
    apb(1'b1, `EGS_OFF_CMD, 32'h0000);
    repeat (2) @(posedge i_clk);
    chk(32'(o_phasing_run), 32'h0, "abort");
    apb(1'b0, `EGS_OFF_COND, 32'h0);
    cb(8, 1'b0, "no done on abort");
    // Following error indication and event
    i_following_error <= 1'b1;
    wb(13, 1'b1, "following error");
    i_following_error <= 1'b0;
    apb(1'b0, `EGS_OFF_IRQ_STS, 32'h0);
    cb(3, 1'b1, "fol err event");
    close_out();
  end
endmodule : egs_gear_slave_tb

/* File: src/egs_gear_slave.sv */
// Electronic gear slave control: command decode, gear sequencer, status and APB registers
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "egs_regs.svh"

// Operation
// - Gear bit ramps to master speed, else stops
// - Correction bit launches master/slave position correction
// - Halt decelerates, stays operation enabled
// - Without halt, gear bit command executes
// - Phasing bit starts phasing; clearing aborts
// - Profile field value n selects profile n+1
// - Status done bit after phasing or correction
// - In-gear bit, or speed zero under halt
// - Correction ok bit once correction finished
// - Mode minus three makes drive follow master
module egs_gear_slave
  import egs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_op_enabled,
  input  wire egs_speed_t  i_master_speed,
  input  wire logic        i_phasing_complete,
  input  wire logic        i_correction_complete,
  input  wire logic        i_following_error,
  output egs_speed_t       o_speed_ref,
  output logic             o_phasing_run,
  output logic      [2:0]  o_phasing_profile,
  output logic             o_correction_run,
  output logic             o_halt_hold,
  output logic             o_irq
);

  // Sticky update: a hardware set wins over a software clear
  function automatic logic [`EGS_IRQ_W-1:0] sticky(input logic [`EGS_IRQ_W-1:0] cur,
                                                   input logic [`EGS_IRQ_W-1:0] clr,
                                                   input logic [`EGS_IRQ_W-1:0] set);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // Address match for one register
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  // Registers
  egs_word_t                cmd;
  logic [7:0]               mode;
  egs_word_t                accel;
  egs_word_t                decel;
  logic [`EGS_IRQ_W-1:0]    irq_sts;
  logic [`EGS_IRQ_W-1:0]    irq_mask;
  egs_gear_e                state;
  egs_gear_e                next_state;
  logic                     phase_run;
  logic                     phase_done;
  logic                     corr_run;
  logic                     corr_done;
  logic                     phase_cmd_q;
  logic                     corr_cmd_q;
  logic                     in_gear_q;
  logic                     fol_err_q;
  logic [2:0]               profile;
  logic                     rd_ok;
  // Which operation owns status bit 8: high after a correction start
  logic                     last_corr;
  logic                     phase_fin;
  logic                     corr_fin;

  // APB decode wires
  logic                     setup;
  logic                     access;
  logic                     wr_en;
  logic                     sel_cmd;
  logic                     sel_cond;
  logic                     sel_mode;
  logic                     sel_accel;
  logic                     sel_decel;
  logic                     sel_sts;
  logic                     sel_mask;
  logic                     mapped;
  logic                     bad;
  logic [31:0]              rd_data;
  egs_word_t                cond;

  // Command decode wires
  logic                     active;
  logic                     gear_cmd;
  logic                     corr_cmd;
  logic                     direct_sync;
  logic                     halt_cmd;
  logic                     phase_cmd;
  logic                     phase_start;
  logic                     corr_start;
  logic                     speed_zero;
  logic                     in_gear;
  logic                     ramp_busy;
  logic [`EGS_IRQ_W-1:0]    irq_set;
  logic [`EGS_IRQ_W-1:0]    irq_clr;
  logic [`EGS_IRQ_W-1:0]    irq_next;

  egs_ramp_if rmp ();

  egs_ramp u_ramp (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .rmp     (rmp.ramp)
  );

  // APB phase and register select
  assign setup     = i_psel & ~i_penable;
  assign access    = i_psel & i_penable;
  assign sel_cmd   = hit(i_paddr, `EGS_OFF_CMD);
  assign sel_cond  = hit(i_paddr, `EGS_OFF_COND);
  assign sel_mode  = hit(i_paddr, `EGS_OFF_MODE);
  assign sel_accel = hit(i_paddr, `EGS_OFF_ACCEL);
  assign sel_decel = hit(i_paddr, `EGS_OFF_DECEL);
  assign sel_sts   = hit(i_paddr, `EGS_OFF_IRQ_STS);
  assign sel_mask  = hit(i_paddr, `EGS_OFF_IRQ_MASK);
  assign mapped    = sel_cmd | sel_cond | sel_mode | sel_accel | sel_decel | sel_sts | sel_mask;
  assign bad       = ~mapped | (i_pwrite & sel_cond);

  // Answer only in access phase, on an enabled edge, with read data loaded
  assign o_pready  = access & i_ce & rd_ok;
  assign o_pslverr = o_pready & bad;
  assign wr_en     = o_pready & i_pwrite & ~bad;

  // Read data mux; unused upper bits read zero
  assign rd_data = sel_cmd   ? {16'h0000, cmd}                      :
                   sel_cond  ? {16'h0000, cond}                     :
                   sel_mode  ? {24'h000000, mode}                   :
                   sel_accel ? {16'h0000, accel}                    :
                   sel_decel ? {16'h0000, decel}                    :
                   sel_sts   ? {28'h0000000, irq_sts}               :
                   sel_mask  ? {28'h0000000, irq_mask}              :
                               32'h00000000;

  // Read data is captured during a selected cycle and marks the answer ready
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      rd_ok    <= 1'b0;
    end else if (i_ce) begin
      o_prdata <= i_psel ? rd_data : o_prdata;
      rd_ok    <= i_psel & ~o_pready;
    end
  end

  // Software registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd      <= `EGS_RST_CMD;
      mode     <= `EGS_RST_MODE;
      accel    <= `EGS_RST_ACCEL;
      decel    <= `EGS_RST_DECEL;
      irq_mask <= `EGS_RST_IRQ;
    end else if (i_ce && wr_en) begin
      if (sel_cmd)   cmd      <= i_pwdata[15:0];
      if (sel_mode)  mode     <= i_pwdata[7:0];
      if (sel_accel) accel    <= i_pwdata[15:0];
      if (sel_decel) decel    <= i_pwdata[15:0];
      if (sel_mask)  irq_mask <= i_pwdata[`EGS_IRQ_W-1:0];
    end
  end

  // Command word fields; gear, correction, halt and phasing bits live only in slave mode with operation enabled
  assign active      = (mode == `EGS_MODE_SLAVE) & i_op_enabled;
  assign gear_cmd    = active & cmd[`EGS_CMD_GEAR];
  assign corr_cmd    = active & cmd[`EGS_CMD_CORR];
  assign direct_sync = ~cmd[`EGS_CMD_SYNC];
  assign halt_cmd    = active & cmd[`EGS_CMD_HALT];
  assign phase_cmd   = active & cmd[`EGS_CMD_PHASE];
  assign profile     = 3'({1'b0, cmd[`EGS_CMD_PSEL_HI:`EGS_CMD_PSEL_LO]}) + 3'h1;

  // Start pulses on a rising command bit
  assign phase_start = phase_cmd & ~phase_cmd_q;
  assign corr_start  = corr_cmd & ~corr_cmd_q;

  // Gear sequencer: halt overrides, otherwise the gear bit decides
  always_comb begin
    next_state = state;
    unique case (state)
      EGS_IDLE: begin
        if (halt_cmd)      next_state = EGS_HALTING;
        else if (gear_cmd) next_state = EGS_RAMP_UP;
      end
      EGS_RAMP_UP: begin
        if (halt_cmd)           next_state = EGS_HALTING;
        else if (!gear_cmd)     next_state = EGS_STOPPING;
        else if (rmp.at_target) next_state = EGS_IN_GEAR;
      end
      EGS_IN_GEAR: begin
        if (halt_cmd)           next_state = EGS_HALTING;
        else if (!gear_cmd)     next_state = EGS_STOPPING;
        else if (!rmp.at_target) next_state = EGS_RAMP_UP;
      end
      EGS_HALTING: begin
        if (!halt_cmd)          next_state = gear_cmd ? EGS_RAMP_UP : EGS_STOPPING;
      end
      EGS_STOPPING: begin
        if (halt_cmd)           next_state = EGS_HALTING;
        else if (gear_cmd)      next_state = EGS_RAMP_UP;
        else if (rmp.at_target) next_state = EGS_IDLE;
      end
    endcase
  end

  // Ramp target and step per state
  assign ramp_busy  = (state == EGS_RAMP_UP) | (state == EGS_IN_GEAR);
  assign rmp.target = ramp_busy ? i_master_speed : '0;
  assign rmp.step   = (ramp_busy && direct_sync) ? `EGS_STEP_DIRECT :
                      ramp_busy                  ? accel            :
                                                   decel;
  assign speed_zero = (rmp.current == '0);

  // Condition bit 10: in gear, or standstill when halted
  assign in_gear = halt_cmd ? speed_zero : (state == EGS_IN_GEAR);

  // Gear sequencer state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= EGS_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // Phasing run/done: start clears done, completion sets it, clearing the bit aborts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_run   <= 1'b0;
      phase_done  <= 1'b0;
      phase_cmd_q <= 1'b0;
    end else if (i_ce) begin
      phase_cmd_q <= phase_cmd;
      if (phase_start) begin
        phase_run  <= 1'b1;
        phase_done <= 1'b0;
      end else if (!phase_cmd) begin
        phase_run  <= 1'b0;
      end else if (phase_run && i_phasing_complete) begin
        phase_run  <= 1'b0;
        phase_done <= 1'b1;
      end
    end
  end

  // Correction run/done: launched only by a rising start bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      corr_run   <= 1'b0;
      corr_done  <= 1'b0;
      corr_cmd_q <= 1'b0;
    end else if (i_ce) begin
      corr_cmd_q <= corr_cmd;
      if (corr_start) begin
        corr_run  <= 1'b1;
        corr_done <= 1'b0;
      end else if (!active) begin
        corr_run  <= 1'b0;
      end else if (corr_run && i_correction_complete) begin
        corr_run  <= 1'b0;
        corr_done <= 1'b1;
      end
    end
  end

  // Status bit 8 follows whichever operation was started last, so a stale
  // completion of the other one cannot show while this one runs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_corr <= 1'b0;
    end else if (i_ce) begin
      if (corr_start) begin
        last_corr <= 1'b1;
      end else if (phase_start) begin
        last_corr <= 1'b0;
      end
    end
  end

  // Condition word: mode-specific bits only
  always_comb begin
    cond                   = 16'h0000;
    cond[`EGS_STS_DONE]    = last_corr ? corr_done : phase_done;
    cond[`EGS_STS_IN_GEAR] = in_gear;
    cond[`EGS_STS_CORR_OK] = corr_done;
    cond[`EGS_STS_FOL_ERR] = i_following_error;
  end

  // Completion events, the same conditions that set the done flags
  assign phase_fin = phase_run & phase_cmd & i_phasing_complete & ~phase_start;
  assign corr_fin  = corr_run & active & i_correction_complete & ~corr_start;

  // Interrupt events on rising in-gear, done flags and following error
  assign irq_set[`EGS_IRQ_IN_GEAR] = in_gear & ~in_gear_q;
  assign irq_set[`EGS_IRQ_PH_DONE] = phase_fin;
  assign irq_set[`EGS_IRQ_CR_DONE] = corr_fin;
  assign irq_set[`EGS_IRQ_FOL_ERR] = i_following_error & ~fol_err_q;
  assign irq_clr = (wr_en && sel_sts) ? i_pwdata[`EGS_IRQ_W-1:0] : `EGS_RST_IRQ;

  // Next status worked out once; feeds the status flops and the interrupt line
  assign irq_next = sticky(irq_sts, irq_clr, irq_set);

  // Sticky interrupt status, write one to clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_sts   <= `EGS_RST_IRQ;
      in_gear_q <= 1'b0;
      fol_err_q <= 1'b0;
    end else if (i_ce) begin
      irq_sts   <= irq_next;
      in_gear_q <= in_gear;
      fol_err_q <= i_following_error;
    end
  end

  // Outputs toward the drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phasing_profile <= 3'h1;
      o_halt_hold       <= 1'b0;
      o_irq             <= 1'b0;
    end else if (i_ce) begin
      o_phasing_profile <= profile;
      o_halt_hold       <= halt_cmd;
      o_irq             <= |(irq_next & irq_mask);
    end
  end

  assign o_speed_ref      = rmp.current;
  assign o_phasing_run    = phase_run;
  assign o_correction_run = corr_run;

endmodule : egs_gear_slave

/* File: src/egs_ramp.sv */
// Speed ramp: moves the speed reference toward its target by a bounded step
`timescale 1ns/1ps
module egs_ramp
  import egs_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  egs_ramp_if.ramp  rmp
);

  logic signed [16:0] diff;
  logic        [16:0] mag;
  logic               close;
  egs_speed_t         current;
  egs_speed_t         next_current;

  // Distance to target and whether one step covers it
  assign diff  = 17'(rmp.target) - 17'(current);
  assign mag   = diff[16] ? 17'(-diff) : diff;
  assign close = mag <= {1'b0, rmp.step};

  // Next speed: land on target or move one step toward it
  assign next_current = close   ? rmp.target :
                        diff[16] ? egs_speed_t'(current - $signed({1'b0, rmp.step[14:0]})) :
                                   egs_speed_t'(current + $signed({1'b0, rmp.step[14:0]}));

  // Speed register, frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      current <= '0;
    end else if (i_ce) begin
      current <= next_current;
    end
  end

  assign rmp.current   = current;
  assign rmp.at_target = (current == rmp.target);

endmodule : egs_ramp
